// file: pkg/and_or_array_pkg.sv
// Constants, register map and helpers for the sum-of-products array.
// Assumes a 10 MHz system clock and an APB slave port for setup.
package and_or_array_pkg;
  // Array geometry
  localparam int unsigned IN_N = 20;
  localparam int unsigned LINE_N = 40;
  localparam int unsigned TERM_N = 64;
  localparam int unsigned CELL_N = 2560;
  localparam int unsigned OUT_N = 8;
  localparam int unsigned GRP_N = 8;
  localparam int unsigned DED_N = 14;
  localparam int unsigned DED_REG_N = 12;
  // Bus geometry
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned CFG_WORDS = 80;
  localparam int unsigned IDX_W = 7;
  // Register offsets
  localparam logic [11:0] STATUS_OFS = 12'h000;
  localparam logic [11:0] CTRL_OFS = 12'h004;
  localparam logic [11:0] CFG_BASE = 12'h100;
  localparam logic [11:0] CFG_END = 12'h240;
  // Field positions
  localparam int unsigned ST_Q_LSB = 0;
  localparam int unsigned ST_DRV_LSB = 8;
  localparam int unsigned ST_OEN_LSB = 16;
  localparam int unsigned ST_SUP_BIT = 24;
  localparam int unsigned ST_LOCK_BIT = 25;
  localparam int unsigned CTRL_LOCK_BIT = 0;
  // Reset values
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  // Preload dwell time
  localparam int unsigned TD_NS = 500;
  localparam int unsigned CLK_NS = 100;
  localparam int unsigned TD_CYC_I = (TD_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CNT_W = 3;
  localparam logic [CNT_W-1:0] TD_CYC = CNT_W'(TD_CYC_I);

  // Mask of registered outputs, centred in the eight
  function automatic logic [OUT_N-1:0] reg_mask(input int unsigned n);
    logic [OUT_N-1:0] m;
    int unsigned lo;
    m = '0;
    lo = (OUT_N - n) / 2;
    for (int unsigned k = 0; k < OUT_N; k++)
    begin
      m[k] = (k >= lo) && (k < lo + n);
    end
    return m;
  endfunction : reg_mask
endpackage : and_or_array_pkg

// file: src/and_or_array.sv
// Sum-of-products logic array with optional output registers.
// Assumes synchronous pins, a testbench that resolves the pin wires,
// and an APB master that loads the cell vector before operation.
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module and_or_array #(
  parameter int unsigned NUM_REG = 8,
  parameter bit VERTICAL = 1'b1,
  parameter bit PRELOAD_EN = 1'b1
) (
  // Clock and power-up reset
  input wire logic CLK_SYS_I,
  input wire logic NRST_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [and_or_array_pkg::ADDR_W-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Dedicated inputs and output pins
  input wire logic [and_or_array_pkg::DED_N-1:0] DED_I,
  input wire logic [and_or_array_pkg::OUT_N-1:0] PIN_I,
  output logic [and_or_array_pkg::OUT_N-1:0] PIN_O,
  output logic [and_or_array_pkg::OUT_N-1:0] PIN_OE_N_O,
  input wire logic OE_N_I,
  input wire logic SUPPLY_OK_I,
  // Preload test controls
  input wire logic PRELOAD_RST_I,
  input wire logic [and_or_array_pkg::OUT_N-1:0] PRELOAD_SET_I,
  input wire logic PRELOAD_LOAD_I
);
  import and_or_array_pkg::*;

  // Which outputs carry a register
  localparam logic [OUT_N-1:0] REG_MASK = reg_mask(NUM_REG);
  // Register state after power-up
  localparam logic [OUT_N-1:0] Q_INIT = VERTICAL ? '0 : '1;

  // Cell storage, one word per index
  logic [31:0] cfg_mem [CFG_WORDS];
  // Flat cell vector, bit n is cell n
  logic [CELL_N-1:0] cfg_flat;
  // Cell connected to its crossing
  logic [CELL_N-1:0] conn;
  // Array inputs and their true/complement lines
  logic [IN_N-1:0] arr_in;
  logic [LINE_N-1:0] lines;
  // Product terms
  logic [TERM_N-1:0] term;
  // Per-output sums and enables
  logic [OUT_N-1:0] d_next;
  logic [OUT_N-1:0] sum_val;
  logic [OUT_N-1:0] oe_term;
  logic [OUT_N-1:0] out_val;
  logic [OUT_N-1:0] out_en;
  // Output registers
  logic [OUT_N-1:0] q_reg;
  // Supply valid as seen by the outputs
  logic sup_ok;
  // Cell write lock
  logic lock_reg;
  // Preload dwell counters
  logic [CNT_W-1:0] rst_cnt_reg;
  logic [CNT_W-1:0] dis_cnt_reg;
  logic [CNT_W-1:0] set_cnt_reg;
  // Preload actions this cycle
  logic pl_clr;
  logic pl_set;
  logic pl_load;
  logic armed;
  // Bus decode
  logic [11:0] cfg_off;
  logic [IDX_W-1:0] cfg_idx;
  logic is_status;
  logic is_ctrl;
  logic is_cfg;
  logic mapped;
  logic apb_setup;
  logic wr_acc;
  logic [31:0] rd_val;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  // First cycle after reset, for checking only
  logic first_reg;

  // Flatten the cell words
  genvar w;
  generate
    for (w = 0; w < CFG_WORDS; w++)
    begin : g_flat
      assign cfg_flat[w*32 +: 32] = cfg_mem[w];
    end
  endgenerate

  // Programmed cell connects in vertical parts, breaks in fuse parts
  assign conn = VERTICAL ? cfg_flat : ~cfg_flat;

  // Array input selection by variant
  generate
    if (NUM_REG == 0)
    begin : g_comb_in
      // Fourteen pins plus six pin feedbacks; ends have none
      assign arr_in = {PIN_I[6:1], DED_I};
    end
    else
    begin : g_reg_in
      // Registers feed back inside, others from their pins
      assign arr_in = {(q_reg & REG_MASK) | (PIN_I & ~REG_MASK),
                       DED_I[DED_REG_N-1:0]};
    end
  endgenerate

  // True line even, complement line odd
  genvar i;
  generate
    for (i = 0; i < IN_N; i++)
    begin : g_line
      assign lines[2*i] = arr_in[i];
      assign lines[2*i+1] = ~arr_in[i];
    end
  endgenerate

  // A term is the AND of its connected lines only
  genvar t;
  generate
    for (t = 0; t < TERM_N; t++)
    begin : g_term
      // Open cells force their line high; both phases kill the term
      assign term[t] = &(~conn[t*LINE_N +: LINE_N] | lines);
    end
  endgenerate

  // Group sums: all eight for registers, seven plus enable otherwise
  genvar k;
  generate
    for (k = 0; k < OUT_N; k++)
    begin : g_sum
      assign d_next[k] = |term[k*GRP_N +: GRP_N];
      assign sum_val[k] = |term[k*GRP_N+1 +: GRP_N-1];
      assign oe_term[k] = term[k*GRP_N];
    end
  endgenerate

  // Supply gate exists only for vertical-cell parts
  assign sup_ok = VERTICAL ? SUPPLY_OK_I : 1'b1;

  // Pin value and enable per output
  always_comb
  begin
    out_val = (q_reg & REG_MASK) | (sum_val & ~REG_MASK);
    // Registered pins share the enable, others use their term
    out_en = ({OUT_N{~OE_N_I}} & REG_MASK) | (oe_term & ~REG_MASK);
    // No output drives without a valid supply
    out_en = out_en & {OUT_N{sup_ok}};
  end

  // Pins drive the inverse, enable is active low
  assign PIN_O = ~out_val;
  assign PIN_OE_N_O = ~out_en;

  // Cycles the preload reset has been held
  always_ff @(posedge CLK_SYS_I or negedge NRST_I)
  begin
    if (!NRST_I)
      rst_cnt_reg <= '0;
    else if (!PRELOAD_RST_I)
      rst_cnt_reg <= '0;
    else if (rst_cnt_reg != TD_CYC)
      rst_cnt_reg <= rst_cnt_reg + 1'b1;
  end

  // Cycles the registered outputs have been disabled
  always_ff @(posedge CLK_SYS_I or negedge NRST_I)
  begin
    if (!NRST_I)
      dis_cnt_reg <= '0;
    else if (!OE_N_I)
      dis_cnt_reg <= '0;
    else if (dis_cnt_reg != TD_CYC)
      dis_cnt_reg <= dis_cnt_reg + 1'b1;
  end

  // Set pulses only count once outputs are disabled long enough
  assign armed = (dis_cnt_reg == TD_CYC) && OE_N_I;

  // Cycles the preload set has been held while armed
  always_ff @(posedge CLK_SYS_I or negedge NRST_I)
  begin
    if (!NRST_I)
      set_cnt_reg <= '0;
    else if (!(armed && |PRELOAD_SET_I))
      set_cnt_reg <= '0;
    else if (set_cnt_reg != TD_CYC)
      set_cnt_reg <= set_cnt_reg + 1'b1;
  end

  // Preload actions; vertical parts clear and set, fuse parts load
  always_comb
  begin
    pl_clr = VERTICAL && PRELOAD_RST_I
             && (rst_cnt_reg >= TD_CYC - 1'b1);
    pl_set = VERTICAL && armed && (|PRELOAD_SET_I)
             && (set_cnt_reg >= TD_CYC - 1'b1);
    // Fuse-link load takes pin data while the outputs are off
    pl_load = !VERTICAL && PRELOAD_EN && PRELOAD_LOAD_I && OE_N_I;
  end

  // Output registers; preload has priority over normal loading
  always_ff @(posedge CLK_SYS_I or negedge NRST_I)
  begin
    if (!NRST_I)
      q_reg <= Q_INIT;
    else if (pl_clr)
      q_reg <= '0;
    else if (pl_set)
      q_reg <= q_reg | (PRELOAD_SET_I & REG_MASK);
    else if (pl_load)
      q_reg <= (q_reg & ~REG_MASK) | (PIN_I & REG_MASK);
    else
      q_reg <= (q_reg & ~REG_MASK) | (d_next & REG_MASK);
  end

  // Address decode
  always_comb
  begin
    cfg_off = PADDR_I - CFG_BASE;
    cfg_idx = cfg_off[IDX_W+1:2];
    is_status = (PADDR_I == STATUS_OFS);
    is_ctrl = (PADDR_I == CTRL_OFS);
    is_cfg = (PADDR_I >= CFG_BASE) && (PADDR_I < CFG_END)
             && (PADDR_I[1:0] == 2'b00);
    mapped = is_status || is_ctrl || is_cfg;
  end

  // Phases of an APB transfer
  assign apb_setup = PSEL_I && !PENABLE_I;
  assign wr_acc = PSEL_I && PENABLE_I && PWRITE_I;

  // Read value for the addressed register
  always_comb
  begin
    rd_val = RDATA_RST;
    if (is_status)
    begin
      // Live state of registers, pins and supply
      rd_val[ST_Q_LSB +: OUT_N] = q_reg;
      rd_val[ST_DRV_LSB +: OUT_N] = PIN_O;
      rd_val[ST_OEN_LSB +: OUT_N] = PIN_OE_N_O;
      rd_val[ST_SUP_BIT] = sup_ok;
      rd_val[ST_LOCK_BIT] = lock_reg;
    end
    else if (is_ctrl)
      rd_val[CTRL_LOCK_BIT] = lock_reg;
    else if (is_cfg)
      rd_val = cfg_mem[cfg_idx];
  end

  // Read data and error are captured in the setup phase
  always_ff @(posedge CLK_SYS_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      prdata_reg <= RDATA_RST;
      pslverr_reg <= 1'b0;
    end
    else if (apb_setup)
    begin
      prdata_reg <= PWRITE_I ? RDATA_RST : rd_val;
      pslverr_reg <= !mapped;
    end
  end

  // Zero wait states; data valid in every access phase
  assign PREADY_O = 1'b1;
  assign PRDATA_O = prdata_reg;
  assign PSLVERR_O = pslverr_reg;

  // Lock is sticky until reset; it freezes the cells
  always_ff @(posedge CLK_SYS_I or negedge NRST_I)
  begin
    if (!NRST_I)
      lock_reg <= 1'b0;
    else if (wr_acc && is_ctrl && PWDATA_I[CTRL_LOCK_BIT])
      lock_reg <= 1'b1;
  end

  // Cell words, written only before the lock is set
  always_ff @(posedge CLK_SYS_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      for (int n = 0; n < CFG_WORDS; n++)
      begin
        cfg_mem[n] <= CFG_RST;
      end
    end
    else if (wr_acc && is_cfg && !lock_reg)
      cfg_mem[cfg_idx] <= PWDATA_I;
  end

  // Marks the first cycle after reset release
  always_ff @(posedge CLK_SYS_I or negedge NRST_I)
  begin
    if (!NRST_I)
      first_reg <= 1'b1;
    else
      first_reg <= 1'b0;
  end

  // Checks
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!NRST_I);

  // Preload reset held for the dwell time
  sequence s_clr_hold;
    PRELOAD_RST_I [*5];
  endsequence

  // Outputs disabled for the dwell time
  sequence s_disable;
    (OE_N_I && !PRELOAD_RST_I) [*5];
  endsequence

  // Set held for the dwell time while disabled
  sequence s_set_hold;
    (OE_N_I && !PRELOAD_RST_I && PRELOAD_SET_I != '0) [*5];
  endsequence

  reset_value_a: assert property (first_reg |-> q_reg == Q_INIT)
    else $error("Registers not at power-up value");

  // Skips the edges around reset release, where the load is not yet live
  reg_load_a: assert property ((!first_reg && !PRELOAD_RST_I && !pl_set && !pl_load)
    |=> ((q_reg ^ $past(d_next)) & REG_MASK) == '0)
    else $error("Register did not load its sum");

  reg_oe_a: assert property (OE_N_I |-> &(PIN_OE_N_O | ~REG_MASK))
    else $error("Registered pin driven while disabled");

  comb_enable_a: assert property (((~PIN_OE_N_O ^ (oe_term & {OUT_N{sup_ok}}))
    & ~REG_MASK) == '0)
    else $error("Combinational enable differs from its term");

  pin_polarity_a: assert property (((PIN_O ^ ~q_reg) & REG_MASK) == '0)
    else $error("Registered pin not inverse of register");

  supply_hiz_a: assert property ((VERTICAL && !SUPPLY_OK_I)
    |-> PIN_OE_N_O == '1)
    else $error("Output enabled without supply");

  preload_clr_a: assert property ((VERTICAL && NUM_REG != 0) and s_clr_hold
    |=> q_reg == '0)
    else $error("Preload reset did not clear registers");

  preload_set_a: assert property ((VERTICAL && NUM_REG != 0)
    and (s_disable ##1 s_set_hold)
    |=> (q_reg & $past(PRELOAD_SET_I) & REG_MASK)
        == ($past(PRELOAD_SET_I) & REG_MASK))
    else $error("Preload set did not set registers");

  preload_load_a: assert property (pl_load
    |=> (q_reg & REG_MASK) == ($past(PIN_I) & REG_MASK))
    else $error("Fuse preload did not load pin data");

  cfg_lock_a: assert property (lock_reg |=> $stable(cfg_flat))
    else $error("Cells changed after lock");

endmodule : and_or_array
`default_nettype wire

// file: tb/pin_bus_model.sv
// Far-side model of the eight output pin wires and what drives them.
// Assumes the bench sets ext_en and ext_val right after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module pin_bus_model (
  // Clock for the floating-line pattern
  input wire logic clk,
  // Device drive
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe_n_o,
  // Outside drivers
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  // Resolved wire level
  output logic [7:0] pin_i
);
  // Level seen on the previous cycle
  logic [7:0] last_q = 8'h00;
  // Device wins when enabled, then the outside driver, else the line flips
  always_comb
  begin
    for (int k = 0; k < 8; k++)
    begin
      if (!pin_oe_n_o[k])
        pin_i[k] = pin_o[k];
      else if (ext_en[k])
        pin_i[k] = ext_val[k];
      else
        pin_i[k] = ~last_q[k];
    end
  end
  // Remember the level so an undriven line never holds its value
  always_ff @(posedge clk)
  begin
    last_q <= pin_i;
  end
endmodule : pin_bus_model
`default_nettype wire

// file: tb/programmable_and_or_array_tb.sv
// Bench for the sum-of-products array built with four registers.
// Assumes vertical cells, the APB slave and the pin wire model.
`timescale 1ns/1ps
`default_nettype none
module programmable_and_or_array_tb;
  import and_or_array_pkg::*;
  // Clock, reset and APB
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // Array side
  logic [DED_N-1:0] ded = 14'h0000;
  logic [7:0] pin_i;
  logic [7:0] pin_o;
  logic [7:0] pin_oe_n;
  logic oe_n = 1'b0;
  logic sup_ok = 1'b1;
  logic pl_rst = 1'b0;
  logic [7:0] pl_set = 8'h00;
  logic [7:0] ext_en = 8'h02;
  logic [7:0] ext_val = 8'h00;
  // Bookkeeping
  logic [31:0] cfg [CFG_WORDS] = '{default: 32'h0000_0000};
  logic [31:0] rd;
  logic err;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;

  and_or_array #(.NUM_REG(4), .VERTICAL(1'b1), .PRELOAD_EN(1'b1)) dut_u (
    .CLK_SYS_I(clk), .NRST_I(nrst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .DED_I(ded), .PIN_I(pin_i),
    .PIN_O(pin_o), .PIN_OE_N_O(pin_oe_n), .OE_N_I(oe_n), .SUPPLY_OK_I(sup_ok),
    .PRELOAD_RST_I(pl_rst), .PRELOAD_SET_I(pl_set), .PRELOAD_LOAD_I(1'b0));

  pin_bus_model pin_u (.clk(clk), .pin_o(pin_o), .pin_oe_n_o(pin_oe_n),
    .ext_en(ext_en), .ext_val(ext_val), .pin_i(pin_i));

  // 10 MHz clock
  always #50 clk = ~clk;

  // Cuts a hung run short
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end

  // Counts and reports one comparison
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // One APB transfer: setup, then access held until pready
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int w;
    w = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && w < 20)
    begin
      @(posedge clk);
      w++;
    end
    if (w == 20)
      n_mismatch++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Connects one line to one term and writes the cell word
  task automatic conn(input int t, input int ln);
    int n;
    logic [31:0] r;
    logic e;
    n = t * LINE_N + ln;
    cfg[n / 32][n % 32] = 1'b1;
    apb(1'b1, ADDR_W'(CFG_BASE + 4 * (n / 32)), cfg[n / 32], r, e);
  endtask : conn

  // Holds a run of terms false by tying both phases of input 0
  task automatic kill(input int t0, input int t1);
    for (int t = t0; t <= t1; t++)
    begin
      conn(t, 0);
      conn(t, 1);
    end
  endtask : kill

  // Status read and an unmapped access
  task automatic t_bus();
    apb(1'b0, ADDR_W'(STATUS_OFS), 32'h0000_0000, rd, err);
    check("status regs", 32'hF, 32'(rd[5:2]));
    check("status supply", 32'h1, 32'(rd[ST_SUP_BIT]));
    apb(1'b0, 12'hFF0, 32'h0000_0000, rd, err);
    check("unmapped err", 32'h1, 32'(err));
    check("unmapped data", 32'h0, rd);
  endtask : t_bus

  // Array image: out0 = in0, out1 off, reg2 = in1, reg3 = reg2, reg5 = pin1
  task automatic cfg_load();
    conn(1, 0);
    kill(2, 7);
    kill(8, 8);
    conn(16, 2);
    kill(17, 23);
    conn(24, 28);
    kill(25, 31);
    conn(40, 26);
    kill(41, 47);
  endtask : cfg_load

  // Combinational output, enable term and an unused input
  task automatic t_comb();
    @(posedge clk);
    ded[0] <= 1'b0;
    #1;
    check("comb low in", 32'h1, 32'(pin_o[0]));
    check("comb enable", 32'h0, 32'(pin_oe_n[0]));
    check("off pin", 32'h1, 32'(pin_oe_n[1]));
    check("open group", 32'h0, 32'(pin_o[6]));
    @(posedge clk);
    ded[0] <= 1'b1;
    #1;
    check("comb high in", 32'h0, 32'(pin_o[0]));
    @(posedge clk);
    ded[5] <= 1'b1;
    #1;
    check("unused input", 32'h0, 32'(pin_o[0]));
  endtask : t_comb

  // Register load, internal feedback while disabled, shared enable
  task automatic t_reg();
    @(posedge clk);
    oe_n <= 1'b1;
    ded[1] <= 1'b0;
    repeat (2) @(posedge clk);
    ded[1] <= 1'b1;
    #60;
    check("no load mid cycle", 32'h3, 32'(pin_o[3:2]));
    @(posedge clk);
    #1;
    check("first stage", 32'h2, 32'(pin_o[3:2]));
    @(posedge clk);
    #1;
    check("fed back stage", 32'h0, 32'(pin_o[3:2]));
    check("shared enable off", 32'hF, 32'(pin_oe_n[5:2]));
    @(posedge clk);
    oe_n <= 1'b0;
    #1;
    check("shared enable on", 32'h0, 32'(pin_oe_n[5:2]));
  endtask : t_reg

  // A disabled pin used as an input
  task automatic t_fb();
    @(posedge clk);
    ext_val[1] <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check("pin feedback high", 32'h0, 32'(pin_o[5]));
    @(posedge clk);
    ext_val[1] <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check("pin feedback low", 32'h1, 32'(pin_o[5]));
  endtask : t_fb

  // Preload clear, then preload set of chosen registers
  task automatic t_pre();
    @(posedge clk);
    pl_rst <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check("clear not yet", 32'h0, 32'(pin_o[4]));
    @(posedge clk);
    #1;
    check("clear all", 32'hF, 32'(pin_o[5:2]));
    @(posedge clk);
    pl_rst <= 1'b0;
    ded[1] <= 1'b0;
    oe_n <= 1'b1;
    repeat (5) @(posedge clk);
    pl_set <= 8'h24;
    #1;
    check("before set", 32'h3, 32'({pin_o[5], pin_o[2]}));
    repeat (5) @(posedge clk);
    #1;
    check("set chosen", 32'h0, 32'({pin_o[5], pin_o[2]}));
    @(posedge clk);
    pl_set <= 8'h00;
    oe_n <= 1'b0;
  endtask : t_pre

  // Cell readback, then the lock freezes the array image
  task automatic t_lock();
    apb(1'b0, ADDR_W'(CFG_BASE + 4), 32'h0000_0000, rd, err);
    check("cell readback", cfg[1], rd);
    apb(1'b1, ADDR_W'(CTRL_OFS), 32'h0000_0001, rd, err);
    apb(1'b0, ADDR_W'(CTRL_OFS), 32'h0000_0000, rd, err);
    check("lock set", 32'h1, rd);
    apb(1'b1, ADDR_W'(CFG_BASE + 4), 32'hFFFF_FFFF, rd, err);
    apb(1'b0, ADDR_W'(CFG_BASE + 4), 32'h0000_0000, rd, err);
    check("cells frozen", cfg[1], rd);
  endtask : t_lock

  // Prints the counts and the verdict, then stops
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test

  // Main sequence; reset spans power-up so no edge loads early
  initial
  begin
    #10;
    check("reg pins in reset", 32'hF, 32'(pin_o[5:2]));
    check("all pins driven", 32'h0, 32'(pin_oe_n));
    @(posedge clk);
    sup_ok <= 1'b0;
    #1;
    check("supply low", 32'hFF, 32'(pin_oe_n));
    @(posedge clk);
    sup_ok <= 1'b1;
    nrst <= 1'b1;
    @(posedge clk);
    #1;
    check("set on first edge", 32'h0, 32'(pin_o));
    t_bus();
    cfg_load();
    t_comb();
    t_reg();
    t_fb();
    t_pre();
    t_lock();
    end_of_test();
  end
endmodule : programmable_and_or_array_tb
`default_nettype wire
